//--- rtl/wpc_cmd_status.sv
// wpc_cmd_status: indexed register access, parameter get/set, calibration
// control and status registers of the weighing transmitter.
// assumes the cyclic data areas are driven by fieldbus logic on clk;
// digital inputs and the lock switch are asynchronous pins.
`timescale 1ns/100ps
// Functional notes
// - index written to register 21 is held
// - get action copies parameter, self-clears
// - start calibration only when switch unlocked
// - range errors set fault code, fault flag
// - value 3 commits data and leaves
// - value 4 discards changes and leaves
// - value 2 loads defaults, resets converter
// - register 0 shows inputs, outputs, limits
// - register 1 byte 0 scale condition
// - converter error is OR of three
// - signal over 36mV or negative flags
// - above full scale and overload flags
// - below zero and center zero flags
// - out of range is below-zero OR overload
// - fault flag cleared by 89 or 121
// - supply loss set at power-on, clearable
// - calibration modified until full scale read
// - byte 2 supply, action, fault flags
// - byte 3 tared, cal modified, analog test
// - write handshake with write-active flag
// - action codes set 80-127, clear +128
// - busy during long action, fault on failure
// - set action takes parameter, self-clears
module wpc_cmd_status
   import wpc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [31:0] writeValue,
   input wire logic [7:0] writeSelect,
   input wire logic [7:0] readSelect,
   output logic [31:0] readValue,
   output logic [7:0] readSelected,
   output logic writeActive,
   input wire logic [2:0] ioInputPins,
   input wire logic calLockPin,
   input wire logic [2:0] outputStates,
   input wire logic [2:0] limitStates,
   input wire logic signed [31:0] grossWeight,
   input wire logic signed [31:0] measSignalUv,
   input wire logic standstillIn,
   input wire logic arithOverflowIn,
   input wire logic taredIn,
   input wire logic analogTestIn,
   output logic [7:0] scaleStatusByte,
   output logic executionPending,
   output logic calibrationActive,
   output logic nvStoreWrite,
   output logic converterReset
);
   logic [2:0] inMeta_reg;
   logic [2:0] inSync_reg;
   logic lockMeta_reg;
   logic lockSync_reg;
   logic [31:0] paramValue_reg;
   logic [31:0] paramIndex_reg;
   logic [31:0] paramWork_reg [PARAM_COUNT];
   logic [31:0] paramSaved_reg [PARAM_COUNT];
   logic [ACT_COUNT-1:0] actionBits_reg;
   wpc_exec_t exState_reg;
   logic opGet_reg;
   logic calMode_reg;
   logic [7:0] faultCode_reg;
   logic fault_reg;
   logic supplyLoss_reg;
   logic calModified_reg;
   logic [2:0] convErrBits;
   logic [7:0] scaleByte;
   logic writeTake;
   logic [31:0] readMux;
   logic fail;
   logic [7:0] failCode;
   logic doStart;
   logic doDefault;
   logic doCommit;
   logic doDiscard;
   logic doWrite;
   logic doGet;
   logic idxOk;
   logic [PIDX_W-1:0] idx;
   logic [31:0] selParam;
   logic clrFault;
   logic clrSupply;
   logic [31:0] regScale;

   function automatic logic isSetCode(input logic [7:0] sel, input logic [7:0] code);
      isSetCode = sel == code;
   endfunction : isSetCode

   function automatic logic isClrCode(input logic [7:0] sel, input logic [7:0] code);
      isClrCode = sel == (code | ACT_CLEAR_OFS);
   endfunction : isClrCode

   // pins pass two flip-flops before use
   always_ff @(posedge clk) begin
      if (srst) begin
         inMeta_reg <= 3'h0;
         inSync_reg <= 3'h0;
         lockMeta_reg <= 1'b1;
         lockSync_reg <= 1'b1;
      end else begin
         inMeta_reg <= ioInputPins;
         inSync_reg <= inMeta_reg;
         lockMeta_reg <= calLockPin;
         lockSync_reg <= lockMeta_reg;
      end
   end

   assign writeTake = writeSelect != 8'h00 && !writeActive;
   assign clrFault = writeTake && (isSetCode(writeSelect, REG_CLR_FAULT)
                     || isSetCode(writeSelect, ACT_CLR_FAULT)
                     || isClrCode(writeSelect, ACT_CLR_FAULT));
   assign clrSupply = writeTake && (isSetCode(writeSelect, REG_CLR_SUPPLY)
                      || isSetCode(writeSelect, ACT_CLR_SUPPLY)
                      || isClrCode(writeSelect, ACT_CLR_SUPPLY));
   assign idx = paramIndex_reg[PIDX_W-1:0];
   assign idxOk = paramIndex_reg < 32'(PARAM_COUNT);
   assign selParam = paramWork_reg[idx];

   // write handshake and register writes
   always_ff @(posedge clk) begin
      if (srst) begin
         writeActive <= 1'b0;
      end else if (writeSelect == 8'h00) begin
         writeActive <= 1'b0;
      end else if (writeTake) begin
         writeActive <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         paramIndex_reg <= 32'h0000_0000;
      end else if (writeTake && writeSelect == REG_PARAM_INDEX) begin
         paramIndex_reg <= writeValue;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         paramValue_reg <= 32'h0000_0000;
      end else if (doGet) begin
         paramValue_reg <= (paramIndex_reg == CAL_CTRL_IDX) ? 32'(calMode_reg)
                           : selParam;
      end else if (writeTake && writeSelect == REG_PARAM_VALUE) begin
         paramValue_reg <= writeValue;
      end
   end

   // action bits: set and clear codes, get/set self-clear on completion
   always_ff @(posedge clk) begin
      if (srst) begin
         actionBits_reg <= '0;
      end else begin
         if (writeTake && writeSelect >= ACT_FIRST && writeSelect <= ACT_LAST
             && writeSelect != ACT_CLR_SUPPLY && writeSelect != ACT_CLR_FAULT) begin
            actionBits_reg[6'(writeSelect - ACT_FIRST)] <= 1'b1;
         end
         if (writeTake && writeSelect >= (ACT_FIRST | ACT_CLEAR_OFS)) begin
            actionBits_reg[6'(writeSelect - (ACT_FIRST | ACT_CLEAR_OFS))] <= 1'b0;
         end
         if (exState_reg == EX_RUN) begin
            actionBits_reg[6'(ACT_SET_PARAM - ACT_FIRST)] <= 1'b0;
            actionBits_reg[6'(ACT_GET_PARAM - ACT_FIRST)] <= 1'b0;
         end
      end
   end

   // execution sequencer: one busy cycle per get/set action
   always_ff @(posedge clk) begin
      if (srst) begin
         exState_reg <= EX_IDLE;
         opGet_reg <= 1'b0;
      end else begin
         unique case (exState_reg)
            EX_IDLE: begin
               if (writeTake && (isSetCode(writeSelect, ACT_SET_PARAM)
                   || isSetCode(writeSelect, ACT_GET_PARAM))) begin
                  exState_reg <= EX_RUN;
                  opGet_reg <= isSetCode(writeSelect, ACT_GET_PARAM);
               end
            end
            EX_RUN: begin
               exState_reg <= EX_IDLE;
            end
         endcase
      end
   end

   assign executionPending = exState_reg == EX_RUN;

   // decode of the running command
   always_comb begin
      fail = 1'b0;
      failCode = 8'h00;
      doStart = 1'b0;
      doDefault = 1'b0;
      doCommit = 1'b0;
      doDiscard = 1'b0;
      doWrite = 1'b0;
      doGet = 1'b0;
      if (exState_reg == EX_RUN) begin
         if (opGet_reg) begin
            doGet = idxOk;
            fail = !idxOk;
            failCode = ERR_RANGE;
         end else if (paramIndex_reg == CAL_CTRL_IDX) begin
            if (paramValue_reg == CAL_START) begin
               if (lockSync_reg) begin
                  fail = 1'b1;
                  failCode = ERR_LOCKED;
               end else if (calMode_reg) begin
                  fail = 1'b1;
                  failCode = ERR_CAL_ACTIVE;
               end else begin
                  doStart = 1'b1;
               end
            end else if (paramValue_reg >= CAL_DEFAULT && paramValue_reg <= CAL_DISCARD) begin
               if (!calMode_reg) begin
                  fail = 1'b1;
                  failCode = ERR_NOT_CAL;
               end else begin
                  doDefault = paramValue_reg == CAL_DEFAULT;
                  doCommit = paramValue_reg == CAL_COMMIT;
                  doDiscard = paramValue_reg == CAL_DISCARD;
               end
            end else begin
               fail = 1'b1;
               failCode = ERR_RANGE;
            end
         end else if (!idxOk || paramValue_reg > PARAM_MAX) begin
            fail = 1'b1;
            failCode = ERR_RANGE;
         end else if (!calMode_reg) begin
            fail = 1'b1;
            failCode = ERR_NOT_CAL;
         end else begin
            doWrite = 1'b1;
         end
      end
   end

   // working and committed parameter sets
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < PARAM_COUNT; i++) begin
            paramWork_reg[i] <= paramDefault(i);
            paramSaved_reg[i] <= paramDefault(i);
         end
      end else begin
         for (int i = 0; i < PARAM_COUNT; i++) begin
            if (doDefault) begin
               paramWork_reg[i] <= paramDefault(i);
            end else if (doDiscard) begin
               paramWork_reg[i] <= paramSaved_reg[i];
            end else if (doWrite && idx == PIDX_W'(i)) begin
               paramWork_reg[i] <= paramValue_reg;
            end
            if (doCommit) begin
               paramSaved_reg[i] <= paramWork_reg[i];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         calMode_reg <= 1'b0;
         nvStoreWrite <= 1'b0;
         converterReset <= 1'b0;
      end else begin
         nvStoreWrite <= doCommit;
         converterReset <= doDefault;
         if (doStart) begin
            calMode_reg <= 1'b1;
         end else if (doCommit || doDiscard) begin
            calMode_reg <= 1'b0;
         end
      end
   end

   assign calibrationActive = calMode_reg;

   // status flags: a set always wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         faultCode_reg <= 8'h00;
         fault_reg <= 1'b0;
      end else begin
         if (fail) begin
            faultCode_reg <= failCode;
            fault_reg <= 1'b1;
         end else if (clrFault) begin
            fault_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         supplyLoss_reg <= 1'b1;
      end else if (clrSupply) begin
         supplyLoss_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         calModified_reg <= 1'b0;
      end else if (calMode_reg || doDefault || doDiscard || doWrite) begin
         calModified_reg <= 1'b1;
      end else if (doGet && paramIndex_reg == FULL_SCALE_IDX) begin
         calModified_reg <= 1'b0;
      end
   end

   wpc_weight_eval u_weight (
      .clk(clk),
      .srst(srst),
      .grossWeight(grossWeight),
      .measSignalUv(measSignalUv),
      .fullScale(paramWork_reg[FULL_SCALE_IDX[PIDX_W-1:0]]),
      .overloadMargin(paramWork_reg[OVL_IDX]),
      .quarterStep(paramWork_reg[QSTEP_IDX]),
      .zeroSetRange(paramWork_reg[ZSR_IDX]),
      .standstillIn(standstillIn),
      .arithOverflowIn(arithOverflowIn),
      .scaleByte(scaleByte),
      .convErrBits(convErrBits)
   );

   assign scaleStatusByte = scaleByte;
   assign regScale = {5'h00, taredIn, calModified_reg, analogTestIn,
                      5'h00, supplyLoss_reg, executionPending, fault_reg,
                      5'h00, convErrBits, scaleByte};

   // register read mux
   always_comb begin
      unique case (readSelect)
         REG_IO_STATE: readMux = {8'h00, 4'h0, limitStates, 1'b0,
                                  4'h0, outputStates, 1'b0, 5'h00, inSync_reg};
         REG_SCALE: readMux = regScale;
         REG_ACT_STATE: readMux = {2'h0, actionBits_reg[13:9], 1'b0,
                                   actionBits_reg[7:0], 16'h0000};
         REG_CAL_INFO: readMux = {faultCode_reg, paramWork_reg[STEP_IDX][7:0],
                                  paramWork_reg[UNIT_IDX][7:0], paramWork_reg[EXPO_IDX][7:0]};
         REG_PARAM_VALUE: readMux = paramValue_reg;
         REG_PARAM_INDEX: readMux = paramIndex_reg;
         default: readMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         readValue <= 32'h0000_0000;
         readSelected <= 8'h00;
      end else begin
         readValue <= readMux;
         readSelected <= readSelect;
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (srst);

   get_copy_a: assert property (doGet && paramIndex_reg != CAL_CTRL_IDX
      |=> paramValue_reg == $past(selParam)) else $error("get did not copy parameter");
   get_clear_a: assert property (exState_reg == EX_RUN && opGet_reg
      |=> !actionBits_reg[6'(ACT_GET_PARAM - ACT_FIRST)]) else $error("get bit stuck");
   cal_locked_a: assert property (exState_reg == EX_RUN && !opGet_reg
      && paramIndex_reg == CAL_CTRL_IDX && paramValue_reg == CAL_START && lockSync_reg
      |=> faultCode_reg == ERR_LOCKED && fault_reg && calMode_reg == $past(calMode_reg))
      else $error("locked start not refused");
   commit_pulse_a: assert property (doCommit
      |=> nvStoreWrite && !calMode_reg ##1 !nvStoreWrite) else $error("commit pulse wrong");
   discard_exit_a: assert property (doDiscard
      |=> !calMode_reg && !nvStoreWrite) else $error("discard did not leave");
   oor_or_a: assert property (scaleByte[SC_OUT_OF_RANGE] ==
      (scaleByte[SC_BELOW_ZERO] | scaleByte[SC_OVERLOAD])) else $error("out of range wrong");
   conv_or_a: assert property (scaleByte[SC_CONV_ERR] == |convErrBits)
      else $error("converter error wrong");
   fault_clear_a: assert property (clrFault && !fail |=> !fault_reg)
      else $error("fault flag not cleared");
   supply_init_a: assert property ($fell(srst) |-> supplyLoss_reg)
      else $error("supply loss not set at power-on");
   busy_pulse_a: assert property (writeTake && isSetCode(writeSelect, ACT_SET_PARAM)
      && exState_reg == EX_IDLE |=> executionPending ##1 !executionPending)
      else $error("busy pulse wrong");
   write_ack_a: assert property (writeTake |=> writeActive ##1
      writeActive == ($past(writeSelect) != 8'h00)) else $error("write handshake wrong");
endmodule : wpc_cmd_status

//--- rtl/wpc_pkg.sv
// wpc_pkg: register numbers, action codes, field positions and fault codes
// of the weighing command and status unit.
// assumes the cyclic input/output areas are exchanged on the unit's clock.
package wpc_pkg;
   // indexed register numbers
   localparam logic [7:0] REG_IO_STATE = 8'h00;
   localparam logic [7:0] REG_SCALE = 8'h01;
   localparam logic [7:0] REG_ACT_STATE = 8'h02;
   localparam logic [7:0] REG_CAL_INFO = 8'h04;
   localparam logic [7:0] REG_PARAM_VALUE = 8'h14;
   localparam logic [7:0] REG_PARAM_INDEX = 8'h15;
   localparam logic [7:0] REG_CLR_SUPPLY = 8'h75;
   localparam logic [7:0] REG_CLR_FAULT = 8'h79;
   // action bit numbers and set/clear code ranges
   localparam logic [7:0] ACT_FIRST = 8'h50;
   localparam logic [7:0] ACT_LAST = 8'h7F;
   localparam logic [7:0] ACT_CLEAR_OFS = 8'h80;
   localparam logic [7:0] ACT_CLR_SUPPLY = 8'h55;
   localparam logic [7:0] ACT_CLR_FAULT = 8'h59;
   localparam logic [7:0] ACT_SET_PARAM = 8'h7B;
   localparam logic [7:0] ACT_GET_PARAM = 8'h7C;
   localparam int ACT_COUNT = 48;
   // parameter table
   localparam int PARAM_COUNT = 32;
   localparam int PIDX_W = 5;
   localparam logic [31:0] CAL_CTRL_IDX = 32'h0000_0014;
   localparam logic [31:0] FULL_SCALE_IDX = 32'h0000_0002;
   localparam logic [PIDX_W-1:0] OVL_IDX = 5'h03;
   localparam logic [PIDX_W-1:0] QSTEP_IDX = 5'h04;
   localparam logic [PIDX_W-1:0] ZSR_IDX = 5'h05;
   localparam logic [PIDX_W-1:0] EXPO_IDX = 5'h06;
   localparam logic [PIDX_W-1:0] UNIT_IDX = 5'h07;
   localparam logic [PIDX_W-1:0] STEP_IDX = 5'h08;
   localparam logic [31:0] PARAM_MAX = 32'h00FF_FFFF;
   // calibration-control values
   localparam logic [31:0] CAL_START = 32'h0000_0001;
   localparam logic [31:0] CAL_DEFAULT = 32'h0000_0002;
   localparam logic [31:0] CAL_COMMIT = 32'h0000_0003;
   localparam logic [31:0] CAL_DISCARD = 32'h0000_0004;
   // fault codes
   localparam logic [7:0] ERR_RANGE = 8'h23;
   localparam logic [7:0] ERR_LOCKED = 8'h28;
   localparam logic [7:0] ERR_NOT_CAL = 8'h29;
   localparam logic [7:0] ERR_CAL_ACTIVE = 8'h2A;
   // scale byte bit positions
   localparam int SC_OUT_OF_RANGE = 7;
   localparam int SC_STANDSTILL = 6;
   localparam int SC_IN_ZERO_SET = 5;
   localparam int SC_CENTER_ZERO = 4;
   localparam int SC_BELOW_ZERO = 3;
   localparam int SC_OVERLOAD = 2;
   localparam int SC_ABOVE_FULL = 1;
   localparam int SC_CONV_ERR = 0;
   // converter signal limit
   localparam int NOEOC_LIMIT_MV = 36;
   localparam logic signed [31:0] NOEOC_LIMIT_UV = 32'(NOEOC_LIMIT_MV * 1000);

   typedef enum logic {EX_IDLE, EX_RUN} wpc_exec_t;

   function automatic logic [31:0] paramDefault(input int idx);
      case (idx)
         2: paramDefault = 32'h0000_2710;
         3: paramDefault = 32'h0000_0064;
         4: paramDefault = 32'h0000_0001;
         5: paramDefault = 32'h0000_00C8;
         7: paramDefault = 32'h0000_0003;
         8: paramDefault = 32'h0000_0001;
         default: paramDefault = 32'h0000_0000;
      endcase
   endfunction : paramDefault
endpackage : wpc_pkg

//--- rtl/wpc_weight_eval.sv
// wpc_weight_eval: registered weight and converter condition flags.
// assumes gross weight and measuring signal come from logic on clk.
`timescale 1ns/100ps
module wpc_weight_eval
   import wpc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic signed [31:0] grossWeight,
   input wire logic signed [31:0] measSignalUv,
   input wire logic [31:0] fullScale,
   input wire logic [31:0] overloadMargin,
   input wire logic [31:0] quarterStep,
   input wire logic [31:0] zeroSetRange,
   input wire logic standstillIn,
   input wire logic arithOverflowIn,
   output logic [7:0] scaleByte,
   output logic [2:0] convErrBits
);
   logic signed [33:0] grossX;
   logic signed [33:0] fsX;
   logic signed [33:0] ovlX;
   logic signed [33:0] qsX;
   logic signed [33:0] zsrX;
   logic e1;
   logic e3;
   logic e7;
   logic belowZero;
   logic overload;

   assign grossX = 34'(grossWeight);
   assign fsX = $signed({2'b00, fullScale});
   assign ovlX = fsX + $signed({2'b00, overloadMargin});
   assign qsX = $signed({2'b00, quarterStep});
   assign zsrX = $signed({2'b00, zeroSetRange});
   assign e1 = arithOverflowIn;
   assign e3 = measSignalUv > NOEOC_LIMIT_UV;
   assign e7 = measSignalUv < 32'sh0000_0000;
   assign belowZero = grossX < -qsX;
   assign overload = grossX > ovlX;

   always_ff @(posedge clk) begin
      if (srst) begin
         scaleByte <= 8'h00;
         convErrBits <= 3'h0;
      end else begin
         convErrBits <= {e1, e3, e7};
         scaleByte[SC_CONV_ERR] <= e1 | e3 | e7;
         scaleByte[SC_ABOVE_FULL] <= grossX > fsX;
         scaleByte[SC_OVERLOAD] <= overload;
         scaleByte[SC_BELOW_ZERO] <= belowZero;
         scaleByte[SC_CENTER_ZERO] <= !belowZero && grossX <= qsX;
         scaleByte[SC_IN_ZERO_SET] <= grossX <= zsrX && grossX >= -zsrX;
         scaleByte[SC_STANDSTILL] <= standstillIn;
         scaleByte[SC_OUT_OF_RANGE] <= belowZero | overload;
      end
   end
endmodule : wpc_weight_eval

//--- sim/wpc_master_model.sv
// wpc_master_model: fieldbus master side, register reads, writes and actions.
// assumes the unit samples on rising clk; drives 1 ns after each edge.
`timescale 1ns/100ps
module wpc_master_model
   import wpc_pkg::*;
(
   input wire logic clk,
   input wire logic [31:0] readValue,
   input wire logic [7:0] readSelected,
   input wire logic writeActive,
   output logic [31:0] writeValue,
   output logic [7:0] writeSelect,
   output logic [7:0] readSelect,
   output logic hung
);
   initial begin
      writeValue = 32'h0;
      writeSelect = 8'h00;
      readSelect = 8'hFF;
      hung = 1'b0;
   end
   task automatic waitAck(input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (writeActive !== lvl && n < 50);
      if (n >= 50) hung = 1'b1;
   endtask : waitAck
   task automatic regWrite(input logic [7:0] sel, input logic [31:0] val);
      writeValue = val;
      writeSelect = sel;
      waitAck(1'b1);
      writeSelect = 8'h00;
      writeValue = ~val;
      waitAck(1'b0);
   endtask : regWrite
   task automatic regRead(input logic [7:0] sel, output logic [31:0] val);
      int n;
      n = 0;
      readSelect = sel;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (readSelected !== sel && n < 50);
      if (n >= 50) hung = 1'b1;
      // one more edge: status that trails a command by a cycle is then shown
      @(posedge clk);
      #1;
      val = readValue;
   endtask : regRead
   task automatic setParam(input logic [31:0] idx, input logic [31:0] val);
      regWrite(REG_PARAM_VALUE, val);
      regWrite(REG_PARAM_INDEX, idx);
      regWrite(ACT_SET_PARAM, 32'h0);
   endtask : setParam
   task automatic getParam(input logic [31:0] idx, output logic [31:0] val);
      regWrite(REG_PARAM_INDEX, idx);
      regWrite(ACT_GET_PARAM, 32'h0);
      regRead(REG_PARAM_VALUE, val);
   endtask : getParam
endmodule : wpc_master_model

//--- sim/weigh_param_cal_status_unit_tb.sv
// weigh_param_cal_status_unit_tb: directed sequences for the command unit.
// assumes wpc_master_model drives the register side of the unit.
`timescale 1ns/100ps
module weigh_param_cal_status_unit_tb
   import wpc_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [31:0] writeValue, readValue, rv;
   logic [7:0] writeSelect, readSelect, readSelected, scaleStatusByte;
   logic writeActive, hung, executionPending, calibrationActive, nvStoreWrite, converterReset;
   logic [2:0] ioInputPins = 3'h5;
   logic [2:0] outputStates = 3'h2;
   logic [2:0] limitStates = 3'h4;
   logic calLockPin = 1'b1;
   logic signed [31:0] grossWeight = 32'h0;
   logic signed [31:0] measSignalUv = 32'h3E8;
   logic standstillIn = 1'b0;
   logic arithOverflowIn = 1'b0;
   logic taredIn = 1'b1;
   logic analogTestIn = 1'b1;
   int errors = 0;
   int comparisons = 0;
   int nvCount = 0;
   int cvCount = 0;
   int pendCount = 0;
   logic [31:0] gw [6] = '{32'h0, 32'h2742, 32'h2775, 32'hFFFF_FE0C, 32'h1388, 32'h1388};
   logic [31:0] ms [6] = '{32'h3E8, 32'h3E8, 32'h3E8, 32'hFFFF_FFFF, 32'h8CA1, 32'h8CA0};
   logic [7:0] sb [6] = '{8'h70, 8'h02, 8'h86, 8'h89, 8'h01, 8'h01};
   logic [2:0] eb [6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h4};
   always #2 clk = ~clk;
   // pulses are counted as they rise, before the master task returns
   always @(posedge nvStoreWrite) nvCount++;
   always @(posedge converterReset) cvCount++;
   always @(posedge executionPending) pendCount++;
   wpc_master_model master (.clk(clk), .readValue(readValue), .readSelected(readSelected),
      .writeActive(writeActive), .writeValue(writeValue), .writeSelect(writeSelect),
      .readSelect(readSelect), .hung(hung));
   wpc_cmd_status dut (.clk(clk), .srst(srst), .writeValue(writeValue),
      .writeSelect(writeSelect), .readSelect(readSelect), .readValue(readValue),
      .readSelected(readSelected), .writeActive(writeActive), .ioInputPins(ioInputPins),
      .calLockPin(calLockPin), .outputStates(outputStates), .limitStates(limitStates),
      .grossWeight(grossWeight), .measSignalUv(measSignalUv), .standstillIn(standstillIn),
      .arithOverflowIn(arithOverflowIn), .taredIn(taredIn), .analogTestIn(analogTestIn),
      .scaleStatusByte(scaleStatusByte), .executionPending(executionPending),
      .calibrationActive(calibrationActive), .nvStoreWrite(nvStoreWrite),
      .converterReset(converterReset));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic rdBit(input string what, input logic [7:0] sel, input int pos,
      input logic exp);
      master.regRead(sel, rv);
      check(what, 32'(exp), 32'(rv[pos]));
   endtask : rdBit
   task automatic rdByte(input string what, input logic [7:0] sel, input logic [7:0] exp);
      master.regRead(sel, rv);
      check(what, 32'(exp), 32'(rv[31:24]));
   endtask : rdByte
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   always @(posedge hung) begin
      errors++;
      $display("Error handshake expected 1 seen 0");
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1;
      srst = 1'b0;
      // let the input synchronisers settle
      repeat (4) @(posedge clk);
      #1;
      master.regRead(REG_IO_STATE, rv);
      check("io state", 32'h0008_0405, rv);
      master.regRead(REG_SCALE, rv);
      check("supply loss", 32'h1, 32'(rv[18]));
      check("status byte3", 32'h5, 32'(rv[26:24]));
      master.getParam(FULL_SCALE_IDX, rv);
      check("full scale", 32'h2710, rv);
      $display("test status and get done");
      master.setParam(CAL_CTRL_IDX, CAL_START);
      check("cal active", 32'h0, 32'(calibrationActive));
      rdByte("locked code", REG_CAL_INFO, ERR_LOCKED);
      rdBit("fault flag", REG_SCALE, 16, 1'b1);
      master.regWrite(REG_CLR_FAULT, 32'h0);
      rdBit("fault clear", REG_SCALE, 16, 1'b0);
      calLockPin = 1'b0;
      master.setParam(CAL_CTRL_IDX, CAL_START);
      check("cal active", 32'h1, 32'(calibrationActive));
      rdBit("cal modified", REG_SCALE, 25, 1'b1);
      master.setParam(CAL_CTRL_IDX, CAL_START);
      rdByte("already in cal", REG_CAL_INFO, ERR_CAL_ACTIVE);
      master.setParam(32'h3, 32'h0100_0000);
      rdByte("range code", REG_CAL_INFO, ERR_RANGE);
      rdBit("fault flag", REG_SCALE, 16, 1'b1);
      master.regWrite(ACT_CLR_FAULT, 32'h0);
      rdBit("fault clear", REG_SCALE, 16, 1'b0);
      master.setParam(CAL_CTRL_IDX, CAL_DEFAULT);
      check("converter reset", 32'h1, 32'(cvCount));
      master.setParam(CAL_CTRL_IDX, CAL_COMMIT);
      check("store write", 32'h1, 32'(nvCount));
      check("cal left", 32'h0, 32'(calibrationActive));
      master.setParam(CAL_CTRL_IDX, CAL_DEFAULT);
      rdByte("not in cal", REG_CAL_INFO, ERR_NOT_CAL);
      master.setParam(CAL_CTRL_IDX, 32'h5);
      rdByte("bad cal value", REG_CAL_INFO, ERR_RANGE);
      $display("test calibration control done");
      master.setParam(CAL_CTRL_IDX, CAL_START);
      master.setParam(FULL_SCALE_IDX, 32'h1388);
      master.setParam(CAL_CTRL_IDX, CAL_DISCARD);
      check("no store", 32'h1, 32'(nvCount));
      master.getParam(FULL_SCALE_IDX, rv);
      check("full scale kept", 32'h2710, rv);
      rdBit("cal modified", REG_SCALE, 25, 1'b0);
      master.regWrite(REG_CLR_SUPPLY, 32'h0);
      rdBit("supply loss", REG_SCALE, 18, 1'b0);
      master.regWrite(ACT_FIRST, 32'h0);
      rdBit("action set", REG_ACT_STATE, 16, 1'b1);
      master.regWrite(ACT_FIRST | ACT_CLEAR_OFS, 32'h0);
      rdBit("action clear", REG_ACT_STATE, 16, 1'b0);
      $display("test undo and clear done");
      for (int i = 0; i < 6; i++) begin
         grossWeight = gw[i];
         measSignalUv = ms[i];
         standstillIn = (i == 0);
         arithOverflowIn = (i == 5);
         repeat (4) @(posedge clk);
         #1;
         check("scale byte", 32'(sb[i]), 32'(scaleStatusByte));
         master.regRead(REG_SCALE, rv);
         check("scale reg", 32'(sb[i]), 32'(rv[7:0]));
         check("error bits", 32'(eb[i]), 32'(rv[10:8]));
      end
      check("busy pulses", 32'h0000_000D, 32'(pendCount));
      $display("test scale flags done");
      end_of_test();
   end
endmodule : weigh_param_cal_status_unit_tb
